// ---- verilog/rtc_defines.svh ----
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
// word offsets (byte addresses) on the register bus
`define OFS_CFG 6'h00
`define OFS_PAD 6'h04
`define OFS_ALCFG 6'h08
`define OFS_TWIN 6'h0c
`define OFS_AWIN 6'h10
`define OFS_KEY 6'h14
`define OFS_EVT 6'h18
// configuration, pad and alarm register fields
`define CFG_EN_BIT 15
`define CFG_WREN_BIT 13
`define CFG_SYNC_BIT 12
`define CFG_HALF_BIT 11
`define CFG_OE_BIT 10
`define CFG_PTR_LSB 8
`define PAD_SEL_BIT 1
`define AL_EN_BIT 15
`define AL_CHIME_BIT 14
`define AL_MASK_LSB 10
`define AL_PTR_LSB 8
// reset values and keys
`define CFG_RESET 16'h0000
`define PAD_RESET 16'h0000
`define AL_RESET 16'h0000
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
// timing: 32.768 kHz timebase from 100 MHz core clock, half-second count
`define CLK_HZ 100000000
`define TB_HZ 32768
`define TB_DIV ((`CLK_HZ + `TB_HZ - 1) / `TB_HZ)
`define HALF_TICKS 16384
// rollover ripple window in core cycles after each half-second tick
`define SYNC_CYCLES 4
`endif

// ---- verilog/rtc_pkg.sv ----
package rtc_pkg;
  typedef enum logic [1:0] {
    PTR_MIN_SEC = 2'h0,
    PTR_WD_HR = 2'h1,
    PTR_MON_DAY = 2'h2,
    PTR_YEAR = 2'h3
  } ptr_t;
  typedef enum logic [2:0] {
    KEY_IDLE = 3'h1,
    KEY_GOT55 = 3'h2,
    KEY_OPEN = 3'h4
  } key_state_t;
endpackage : rtc_pkg

// ---- verilog/rtc_timebase.sv ----
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_timebase (
  input wire logic clk_in, // core clock
  input wire logic rst_in, // synchronous reset
  input wire logic run_in, // module enabled
  input wire logic clr_in, // restart the half-second phase
  output logic half_tick_out, // one-cycle pulse each half second
  output logic half_out // second half of a second
);
  logic [11:0] div_ff, nxt_div;
  logic [13:0] cnt_ff, nxt_cnt;
  logic half_ff, nxt_half;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_div = div_ff;
    nxt_cnt = cnt_ff;
    nxt_half = half_ff;
    nxt_tick = 1'b0;
    if (clr_in) begin
      nxt_cnt = 14'h0;
      nxt_half = 1'b0;
    end else if (run_in) begin
      if (div_ff == 12'(`TB_DIV - 1)) begin
        nxt_div = 12'h0;
        if (cnt_ff == 14'(`HALF_TICKS - 1)) begin
          nxt_cnt = 14'h0;
          nxt_half = ~half_ff;
          nxt_tick = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 14'h1;
        end
      end else begin
        nxt_div = div_ff + 12'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_ff <= 12'h0;
      cnt_ff <= 14'h0;
      half_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      half_ff <= nxt_half;
      tick_ff <= nxt_tick;
    end
  end

  assign half_tick_out = tick_ff;
  assign half_out = half_ff;
endmodule : rtc_timebase

// ---- verilog/rtc_regs.sv ----
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_regs (
  input wire logic clk_in, // core clock
  input wire logic rst_in, // system reset
  input wire logic por_in, // power-on reset
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write
  input wire logic [5:0] wb_adr_in, // byte address
  input wire logic [3:0] wb_sel_in, // byte selects
  input wire logic [31:0] wb_dat_in, // write data
  output logic [31:0] wb_dat_out, // read data
  output logic wb_ack_out, // acknowledge
  input wire logic alarm_match_in, // alarm compare hit from time chain
  output logic pin_out, // clock pin level
  output logic pin_oe_n_out // clock pin enable, low drives
);
  logic [15:0] cfg_ff, nxt_cfg;
  logic pad_sel_ff, nxt_pad_sel;
  logic [15:0] al_ff, nxt_al;
  logic [7:0] tv_ff [0:7];
  logic [7:0] nxt_tv [0:7];
  logic [7:0] av_ff [0:5];
  logic [7:0] nxt_av [0:5];
  rtc_pkg::key_state_t key_ff, nxt_key;
  logic [31:0] rdat_ff, nxt_rdat;
  logic ack_ff, nxt_ack;
  logic [2:0] sync_ff, nxt_sync;
  logic pulse_ff, nxt_pulse;
  logic half_tick, half_phase, clr_half;
  logic req, wr, rd, hi_w, lo_w, wren;
  logic [1:0] tptr, aptr;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] step_down(input logic [1:0] p);
    step_down = (p == 2'h0) ? 2'h0 : p - 2'h1;
  endfunction : step_down

  function automatic logic [7:0] bcd_mask(input logic [1:0] p, input logic hi);
    logic [7:0] m;
    m = 8'hff;
    unique case (rtc_pkg::ptr_t'(p))
      rtc_pkg::PTR_MIN_SEC: m = 8'h7f;
      rtc_pkg::PTR_WD_HR: m = hi ? 8'h07 : 8'h3f;
      rtc_pkg::PTR_MON_DAY: m = hi ? 8'h1f : 8'h3f;
      rtc_pkg::PTR_YEAR: m = hi ? 8'h00 : 8'hff;
    endcase
    bcd_mask = m;
  endfunction : bcd_mask

  rtc_timebase u_tb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(cfg_ff[`CFG_EN_BIT]),
    .clr_in(clr_half),
    .half_tick_out(half_tick),
    .half_out(half_phase)
  );

  assign req = wb_cyc_in & wb_stb_in & ~ack_ff;
  assign wr = req & wb_we_in;
  assign rd = req & ~wb_we_in;
  assign hi_w = wr & wb_sel_in[1];
  assign lo_w = wr & wb_sel_in[0];
  assign wren = cfg_ff[`CFG_WREN_BIT];
  assign tptr = cfg_ff[`CFG_PTR_LSB +: 2];
  assign aptr = al_ff[`AL_PTR_LSB +: 2];
  assign clr_half = lo_w & wren & (wb_adr_in == `OFS_TWIN) & (tptr == 2'h0);

  // ------------------------------------------------------------
  // key sequence
  // ------------------------------------------------------------
  always_comb begin
    nxt_key = key_ff;
    unique case (key_ff)
      rtc_pkg::KEY_IDLE:
        if (wr && wb_adr_in == `OFS_KEY && wb_dat_in[7:0] == `KEY_FIRST) begin
          nxt_key = rtc_pkg::KEY_GOT55;
        end
      rtc_pkg::KEY_GOT55:
        if (wr && wb_adr_in == `OFS_KEY && wb_dat_in[7:0] == `KEY_SECOND) begin
          nxt_key = rtc_pkg::KEY_OPEN;
        end else if (wr) begin
          nxt_key = rtc_pkg::KEY_IDLE;
        end
      rtc_pkg::KEY_OPEN:
        if (wr) begin
          nxt_key = rtc_pkg::KEY_IDLE;
        end
      default: nxt_key = rtc_pkg::KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key_ff <= rtc_pkg::KEY_IDLE;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // ------------------------------------------------------------
  // configuration and pad registers
  // ------------------------------------------------------------
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_pad_sel = pad_sel_ff;
    nxt_sync = (sync_ff != 3'h0) ? sync_ff - 3'h1 : 3'h0;
    if (half_tick) begin
      nxt_sync = 3'(`SYNC_CYCLES);
    end
    if (wr && wb_adr_in == `OFS_CFG) begin
      if (wb_sel_in[0]) begin
        nxt_cfg[7:0] = wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        nxt_cfg[`CFG_OE_BIT] = wb_dat_in[`CFG_OE_BIT];
        nxt_cfg[`CFG_PTR_LSB +: 2] = wb_dat_in[`CFG_PTR_LSB +: 2];
        nxt_cfg[`CFG_WREN_BIT] = wb_dat_in[`CFG_WREN_BIT] &
          (~wren ? (key_ff == rtc_pkg::KEY_OPEN) : 1'b1);
        if (wren) begin
          nxt_cfg[`CFG_EN_BIT] = wb_dat_in[`CFG_EN_BIT];
        end
      end
    end else if (rd && wb_adr_in == `OFS_TWIN) begin
      nxt_cfg[`CFG_PTR_LSB +: 2] = step_down(tptr);
    end else if (hi_w && wb_adr_in == `OFS_TWIN) begin
      nxt_cfg[`CFG_PTR_LSB +: 2] = step_down(tptr);
    end
    if (wr && wb_adr_in == `OFS_PAD && wb_sel_in[0]) begin
      nxt_pad_sel = wb_dat_in[`PAD_SEL_BIT];
    end
    nxt_cfg[14] = 1'b0;
    nxt_cfg[`CFG_SYNC_BIT] = 1'b0;
    nxt_cfg[`CFG_HALF_BIT] = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (por_in) begin
      cfg_ff <= `CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
    if (rst_in) begin
      pad_sel_ff <= 1'b0;
      sync_ff <= 3'h0;
    end else begin
      pad_sel_ff <= nxt_pad_sel;
      sync_ff <= nxt_sync;
    end
  end

  // ------------------------------------------------------------
  // alarm configuration and events
  // ------------------------------------------------------------
  always_comb begin
    nxt_al = al_ff;
    nxt_pulse = 1'b0;
    if (wr && wb_adr_in == `OFS_ALCFG) begin
      if (wb_sel_in[0]) begin
        nxt_al[7:0] = wb_dat_in[7:0];
      end
      if (wb_sel_in[1]) begin
        nxt_al[15:8] = wb_dat_in[15:8];
      end
    end else if (rd && wb_adr_in == `OFS_AWIN) begin
      nxt_al[`AL_PTR_LSB +: 2] = step_down(aptr);
    end else if (hi_w && wb_adr_in == `OFS_AWIN) begin
      nxt_al[`AL_PTR_LSB +: 2] = step_down(aptr);
    end
    // reserved mask code 5 never fires
    if (alarm_match_in && al_ff[`AL_EN_BIT] && al_ff[`AL_MASK_LSB + 3 -: 3] != 3'h5) begin
      nxt_pulse = 1'b1;
      if (al_ff[7:0] != 8'h00 || al_ff[`AL_CHIME_BIT]) begin
        nxt_al[7:0] = al_ff[7:0] - 8'h01;
      end else begin
        nxt_al[`AL_EN_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      al_ff <= `AL_RESET;
      pulse_ff <= 1'b0;
    end else begin
      al_ff <= nxt_al;
      pulse_ff <= nxt_pulse;
    end
  end

  // ------------------------------------------------------------
  // value windows
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_tv[i] = tv_ff[i];
    end
    for (int i = 0; i < 6; i++) begin
      nxt_av[i] = av_ff[i];
    end
    if (wren && wb_adr_in == `OFS_TWIN) begin
      if (hi_w) begin
        nxt_tv[{tptr, 1'b1}] = wb_dat_in[15:8] & bcd_mask(tptr, 1'b1);
      end
      if (lo_w) begin
        nxt_tv[{tptr, 1'b0}] = wb_dat_in[7:0] & bcd_mask(tptr, 1'b0);
      end
    end
    if (wr && wb_adr_in == `OFS_AWIN && aptr != 2'h3) begin
      if (hi_w) begin
        nxt_av[3'({aptr, 1'b1})] = wb_dat_in[15:8] & bcd_mask(aptr, 1'b1);
      end
      if (lo_w) begin
        nxt_av[3'({aptr, 1'b0})] = wb_dat_in[7:0] & bcd_mask(aptr, 1'b0);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 8; i++) begin
      tv_ff[i] <= rst_in ? 8'h00 : nxt_tv[i];
    end
    for (int i = 0; i < 6; i++) begin
      av_ff[i] <= rst_in ? 8'h00 : nxt_av[i];
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  always_comb begin
    nxt_ack = req;
    nxt_rdat = 32'h0;
    if (rd) begin
      unique case (wb_adr_in)
        `OFS_CFG: nxt_rdat = {16'h0, cfg_ff[15:13], (sync_ff != 3'h0), half_phase,
          cfg_ff[10:0]};
        `OFS_PAD: nxt_rdat = {30'h0, pad_sel_ff, 1'b0};
        `OFS_ALCFG: nxt_rdat = {16'h0, al_ff};
        `OFS_TWIN: nxt_rdat = {16'h0, tv_ff[{tptr, 1'b1}], tv_ff[{tptr, 1'b0}]};
        `OFS_AWIN: nxt_rdat = (aptr == 2'h3) ? 32'h0 :
          {16'h0, av_ff[3'({aptr, 1'b1})], av_ff[3'({aptr, 1'b0})]};
        `OFS_EVT: nxt_rdat = {31'h0, al_ff[`AL_EN_BIT]};
        default: nxt_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;
  assign pin_out = pad_sel_ff ? half_phase : pulse_ff;
  assign pin_oe_n_out = ~cfg_ff[`CFG_OE_BIT];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  lock_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !wren |=> $stable(tv_ff[0]) && $stable(tv_ff[1]))
    else $error("time value changed while locked");
  en_lock_a: assert property (@(posedge clk_in) disable iff (rst_in | por_in)
    !wren |=> $stable(cfg_ff[`CFG_EN_BIT]))
    else $error("enable changed while locked");
  wren_key_a: assert property (@(posedge clk_in) disable iff (rst_in | por_in)
    $rose(cfg_ff[`CFG_WREN_BIT]) |-> $past(key_ff) == rtc_pkg::KEY_OPEN)
    else $error("write enable set without key");
  tptr_floor_a: assert property (@(posedge clk_in) disable iff (rst_in | por_in)
    tptr == 2'h0 && rd && wb_adr_in == `OFS_TWIN |=> tptr == 2'h0)
    else $error("time pointer left zero");
  aptr_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    aptr == 2'h2 && rd && wb_adr_in == `OFS_AWIN |=> aptr == 2'h1)
    else $error("alarm pointer did not step");
  ack_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  pin_off_a: assert property (@(posedge clk_in) disable iff (rst_in | por_in)
    wr && wb_adr_in == `OFS_CFG && wb_sel_in[1]
    |=> pin_oe_n_out == !$past(wb_dat_in[`CFG_OE_BIT]))
    else $error("pin enable does not follow write");
  alarm_stop_a: assert property (@(posedge clk_in) disable iff (rst_in)
    nxt_pulse && al_ff[7:0] == 8'h00 && !al_ff[`AL_CHIME_BIT] && !wr
    |=> !al_ff[`AL_EN_BIT])
    else $error("alarm enable not cleared");
endmodule : rtc_regs

// ---- verif/rtc_regs_tb.sv ----
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic match = 1'b0;
  logic pin;
  logic pin_oe_n;
  logic [31:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  rtc_regs dut (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .alarm_match_in(match), .pin_out(pin), .pin_oe_n_out(pin_oe_n)
  );

  always #5 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // hang guard, tests take well under 2000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ------------------------------------------------------------
  // wishbone classic single cycle
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] s,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("[FAIL] ack expected 1 seen %b", ack);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [3:0] s, input logic [15:0] d);
    bus(1'b1, a, s, d);
  endtask : wr

  task automatic rdc(input string name, input logic [5:0] a, input logic [15:0] exp);
    bus(1'b0, a, 4'h3, 16'h0000);
    chk(name, {16'h0000, exp}, rd);
  endtask : rdc

  task automatic fire(input logic exp);
    @(posedge clk_in);
    match <= 1'b1;
    @(posedge clk_in);
    match <= 1'b0;
    @(posedge clk_in);
    chk("pulse", {31'h0, exp}, {31'h0, pin});
    repeat (2) @(posedge clk_in);
  endtask : fire

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    rdc("cfg", `OFS_CFG, 16'h0000);
    rdc("pad", `OFS_PAD, 16'h0000);
    rdc("alcfg", `OFS_ALCFG, 16'h0000);
    rdc("unmapped", 6'h1c, 16'h0000);
    wr(`OFS_CFG, 4'h3, 16'h8700);
    rdc("cfg", `OFS_CFG, 16'h0700);
    chk("oe_n", 32'h0, {31'h0, pin_oe_n});
    wr(`OFS_TWIN, 4'h1, 16'h0042);
    rdc("year", `OFS_TWIN, 16'h0000);
    rdc("cfg", `OFS_CFG, 16'h0600);
    wr(`OFS_KEY, 4'h1, 16'h0055);
    wr(`OFS_PAD, 4'h3, 16'h0000);
    wr(`OFS_KEY, 4'h1, 16'h00aa);
    wr(`OFS_CFG, 4'h3, 16'h2700);
    rdc("cfg", `OFS_CFG, 16'h0700);
    wr(`OFS_KEY, 4'h1, 16'h0055);
    wr(`OFS_KEY, 4'h1, 16'h00aa);
    wr(`OFS_CFG, 4'h3, 16'ha700);
    rdc("cfg", `OFS_CFG, 16'h2700);
    wr(`OFS_CFG, 4'h3, 16'ha700);
    wr(`OFS_TWIN, 4'h1, 16'h0099);
    rdc("cfg", `OFS_CFG, 16'ha700);
    rdc("year", `OFS_TWIN, 16'h0099);
    wr(`OFS_TWIN, 4'h3, 16'h0112);
    wr(`OFS_TWIN, 4'h3, 16'h0523);
    wr(`OFS_TWIN, 4'h3, 16'h5959);
    rdc("cfg", `OFS_CFG, 16'ha400);
    rdc("minutes_seconds_register", `OFS_TWIN, 16'h5959);
    wr(`OFS_CFG, 4'h3, 16'ha600);
    rdc("monday", `OFS_TWIN, 16'h0112);
    rdc("wdhr", `OFS_TWIN, 16'h0523);
    wr(`OFS_CFG, 4'h3, 16'h8700);
    wr(`OFS_CFG, 4'h3, 16'h0700);
    rdc("cfg", `OFS_CFG, 16'h8700);
    wr(`OFS_TWIN, 4'h1, 16'h0000);
    rdc("year", `OFS_TWIN, 16'h0099);
    // alarm window pointer walk
    wr(`OFS_ALCFG, 4'h3, 16'h0200);
    wr(`OFS_AWIN, 4'h3, 16'h1231);
    rdc("alcfg", `OFS_ALCFG, 16'h0100);
    wr(`OFS_AWIN, 4'h1, 16'h0023);
    rdc("alcfg", `OFS_ALCFG, 16'h0100);
    bus(1'b0, `OFS_AWIN, 4'h2, 16'h0000);
    chk("alwdhr", 32'h0023, rd);
    wr(`OFS_AWIN, 4'h3, 16'h3045);
    rdc("alminsec", `OFS_AWIN, 16'h3045);
    rdc("alcfg", `OFS_ALCFG, 16'h0000);
    wr(`OFS_ALCFG, 4'h3, 16'h0300);
    rdc("alnone", `OFS_AWIN, 16'h0000);
    rdc("almonday", `OFS_AWIN, 16'h1231);
    rdc("alcfg", `OFS_ALCFG, 16'h0100);
    // repeat count, chime, reserved mask
    wr(`OFS_ALCFG, 4'h3, 16'h8001);
    fire(1'b1);
    rdc("alcfg", `OFS_ALCFG, 16'h8000);
    fire(1'b1);
    rdc("alcfg", `OFS_ALCFG, 16'h0000);
    wr(`OFS_ALCFG, 4'h3, 16'hc000);
    fire(1'b1);
    rdc("alcfg", `OFS_ALCFG, 16'hc0ff);
    wr(`OFS_ALCFG, 4'h3, 16'ha801);
    fire(1'b0);
    rdc("alcfg", `OFS_ALCFG, 16'ha801);
    // system reset leaves configuration alone, clears alarm configuration
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc("cfg", `OFS_CFG, 16'h8600);
    rdc("alcfg", `OFS_ALCFG, 16'h0000);
    wr(`OFS_CFG, 4'h3, 16'h0000);
    rdc("cfg", `OFS_CFG, 16'h8000);
    chk("oe_n", 32'h1, {31'h0, pin_oe_n});
    conclude();
  end
endmodule : rtc_regs_tb
